// >>> rtl/gdsc_pkg.sv
// Constants and state encodings for the gate driver start-up control.
package gdsc_pkg;
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned POR_TIME_MS = 3000;
	localparam int unsigned RECOVER_TIME_MS = 20000;
	localparam longint unsigned POR_CYCLES = longint'(POR_TIME_MS) * 1000 * CLK_MHZ;
	localparam longint unsigned RECOVER_CYCLES = longint'(RECOVER_TIME_MS) * 1000 * CLK_MHZ;
	localparam int unsigned CNT_W = 33;
	localparam logic GATE_OFF = 1'b0;
	localparam logic STATUS_NOT_READY = 1'b0;
	localparam logic [CNT_W-1:0] CNT_RESET = 33'h0_0000_0000;
	typedef enum logic [1:0] {
		ST_POR = 2'b00,
		ST_RUN = 2'b01,
		ST_FAULT = 2'b10
	} state_t;
endpackage : gdsc_pkg

// >>> rtl/gdsc_gate_if.sv
// Interface carrying decoded switching requests and the gating permission.
`timescale 1ns/1ps
`default_nettype none
interface gdsc_gate_if;
	logic hs_req;
	logic ls_req;
	logic permit_hs;
	logic permit_ls;
	logic hs_on;
	logic ls_on;
	modport ctrl (output permit_hs, output permit_ls, input hs_req, input ls_req);
	modport stage (input permit_hs, input permit_ls, output hs_req, output ls_req,
		output hs_on, output ls_on);
endinterface : gdsc_gate_if
`default_nettype wire

// >>> rtl/gdsc_input_stage.sv
// Differential input decode and registered gate output stage.
`timescale 1ns/1ps
`default_nettype none
module gdsc_input_stage (
	// Clock and reset.
	input wire logic clk,
	input wire logic arst_n,
	// Differential switching inputs.
	input wire logic hs_p,
	input wire logic hs_n,
	input wire logic ls_p,
	input wire logic ls_n,
	// Link to the control.
	gdsc_gate_if.stage gate
);
	logic next_hs_on;
	logic next_ls_on;
	logic hs_on_q;
	logic ls_on_q;

	// A pair reads on only when both lines disagree in the on direction.
	always_comb begin
		gate.hs_req = hs_p & ~hs_n;
		gate.ls_req = ls_p & ~ls_n;
		next_hs_on = gate.hs_req & gate.permit_hs;
		next_ls_on = gate.ls_req & gate.permit_ls;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hs_on_q <= gdsc_pkg::GATE_OFF;
			ls_on_q <= gdsc_pkg::GATE_OFF;
		end else begin
			hs_on_q <= next_hs_on;
			ls_on_q <= next_ls_on;
		end
	end

	assign gate.hs_on = hs_on_q;
	assign gate.ls_on = ls_on_q;

	AST_GATE_NEEDS_PERMIT: assert property (@(posedge clk) disable iff (!arst_n)
		gate.hs_on |-> $past(gate.permit_hs)) else $error("High side on without permit.");
	AST_DIFF_DECODE: assert property (@(posedge clk) disable iff (!arst_n)
		(hs_p && hs_n) |-> !gate.hs_req) else $error("Equal pair decoded as on.");
endmodule : gdsc_input_stage
`default_nettype wire

// >>> rtl/gdsc_top.sv
// Start-up, fault handling and output gating of the two-channel driver core.
// Contract
// - Power-on reset runs 3 s after supply on before ready.
// - Status output and halt input carry meaning only after power-on reset.
// - At reset end with no fault, status output leaves not-ready.
// - Shutdown disable strap low enables automatic fault shutdown, high disables it.
// - Switching inputs are differential pairs decoded from their difference.
// - Fault drives status not-ready, latches error, forces gates off, blocks pulses.
// - Recovery needs fault gone and at least 20 s since detection.
// - With shutdown disabled, fault only shows on status; controller turns off.
`timescale 1ns/1ps
`default_nettype none
module gdsc_top #(
	// Interval lengths in clock cycles; shorter values serve simulation only.
	parameter longint unsigned POR_LEN = gdsc_pkg::POR_CYCLES,
	parameter longint unsigned RECOVER_LEN = gdsc_pkg::RECOVER_CYCLES
) (
	// Clock and reset.
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	// Differential switching inputs.
	input wire logic HS_IN_P,
	input wire logic HS_IN_N,
	input wire logic LS_IN_P,
	input wire logic LS_IN_N,
	// Halt request from the controller and fault sense.
	input wire logic HALT_REQ,
	input wire logic FAULT_IN,
	// Shutdown disable straps, high means shutdown disabled.
	input wire logic HIGH_SIDE_FAULT_SHUTDOWN_DISABLE,
	input wire logic LOW_SIDE_FAULT_SHUTDOWN_DISABLE,
	// Gate outputs.
	output logic HIGH_SIDE_TURN_ON_OUT,
	output logic HIGH_SIDE_TURN_OFF_OUT,
	output logic LOW_SIDE_TURN_ON_OUT,
	output logic LOW_SIDE_TURN_OFF_OUT,
	// Status.
	output logic READY_STATUS,
	output logic ERROR_LATCH
);
	gdsc_gate_if gate ();

	gdsc_pkg::state_t state;
	gdsc_pkg::state_t next_state;
	logic [gdsc_pkg::CNT_W-1:0] cnt;
	logic [gdsc_pkg::CNT_W-1:0] next_cnt;
	logic ready;
	logic next_ready;
	logic err;
	logic next_err;
	logic hs_dis;
	logic ls_dis;
	logic next_hs_dis;
	logic next_ls_dis;
	logic fault;
	logic hs_off;
	logic ls_off;
	logic next_hs_off;
	logic next_ls_off;

	function automatic logic [gdsc_pkg::CNT_W-1:0] sat_inc(input logic [gdsc_pkg::CNT_W-1:0] v);
		sat_inc = (&v) ? v : v + 1'b1;
	endfunction : sat_inc

	function automatic logic reached(input logic [gdsc_pkg::CNT_W-1:0] v,
		input longint unsigned lim);
		reached = v >= gdsc_pkg::CNT_W'(lim - 1);
	endfunction : reached

	function automatic logic gate_off_level(input logic req, input logic permit);
		gate_off_level = ~(req & permit);
	endfunction : gate_off_level

	// The halt request is ignored until the power-on reset is over.
	assign fault = FAULT_IN | (HALT_REQ & (state != gdsc_pkg::ST_POR));

	gdsc_input_stage u_stage (
		.clk(SYS_CLK),
		.arst_n(ARST_N),
		.hs_p(HS_IN_P),
		.hs_n(HS_IN_N),
		.ls_p(LS_IN_P),
		.ls_n(LS_IN_N),
		.gate(gate.stage)
	);

	always_comb begin
		next_state = state;
		next_cnt = sat_inc(cnt);
		next_err = err;
		next_ready = ready;
		next_hs_dis = hs_dis;
		next_ls_dis = ls_dis;
		case (state)
			gdsc_pkg::ST_POR: begin
				next_ready = gdsc_pkg::STATUS_NOT_READY;
				// Straps are captured once power-on reset has elapsed.
				if (reached(cnt, POR_LEN)) begin
					next_hs_dis = HIGH_SIDE_FAULT_SHUTDOWN_DISABLE;
					next_ls_dis = LOW_SIDE_FAULT_SHUTDOWN_DISABLE;
					next_cnt = gdsc_pkg::CNT_RESET;
					if (fault) begin
						next_state = gdsc_pkg::ST_FAULT;
						next_err = 1'b1;
					end else begin
						next_state = gdsc_pkg::ST_RUN;
						next_ready = 1'b1;
					end
				end
			end
			gdsc_pkg::ST_RUN: begin
				next_cnt = gdsc_pkg::CNT_RESET;
				if (fault) begin
					next_state = gdsc_pkg::ST_FAULT;
					next_ready = gdsc_pkg::STATUS_NOT_READY;
					next_err = 1'b1;
				end
			end
			gdsc_pkg::ST_FAULT: begin
				next_ready = gdsc_pkg::STATUS_NOT_READY;
				if (!fault && reached(cnt, RECOVER_LEN)) begin
					next_state = gdsc_pkg::ST_RUN;
					next_ready = 1'b1;
					next_err = 1'b0;
					next_cnt = gdsc_pkg::CNT_RESET;
				end
			end
			default: begin
				next_state = gdsc_pkg::ST_POR;
				next_cnt = gdsc_pkg::CNT_RESET;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state <= gdsc_pkg::ST_POR;
			cnt <= gdsc_pkg::CNT_RESET;
			ready <= gdsc_pkg::STATUS_NOT_READY;
			err <= 1'b0;
			hs_dis <= 1'b0;
			ls_dis <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			ready <= next_ready;
			err <= next_err;
			hs_dis <= next_hs_dis;
			ls_dis <= next_ls_dis;
		end
	end

	// Pulses pass in run; in fault only a side whose shutdown is disabled passes.
	always_comb begin
		gate.permit_hs = (state == gdsc_pkg::ST_RUN) && !fault;
		gate.permit_ls = (state == gdsc_pkg::ST_RUN) && !fault;
		if (state == gdsc_pkg::ST_FAULT || (state == gdsc_pkg::ST_RUN && fault)) begin
			gate.permit_hs = hs_dis;
			gate.permit_ls = ls_dis;
		end
	end

	// Turn-off drives get flops of their own so that no output passes an inverter.
	always_comb begin
		next_hs_off = gate_off_level(gate.hs_req, gate.permit_hs);
		next_ls_off = gate_off_level(gate.ls_req, gate.permit_ls);
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			hs_off <= ~gdsc_pkg::GATE_OFF;
			ls_off <= ~gdsc_pkg::GATE_OFF;
		end else begin
			hs_off <= next_hs_off;
			ls_off <= next_ls_off;
		end
	end

	assign HIGH_SIDE_TURN_ON_OUT = gate.hs_on;
	assign HIGH_SIDE_TURN_OFF_OUT = hs_off;
	assign LOW_SIDE_TURN_ON_OUT = gate.ls_on;
	assign LOW_SIDE_TURN_OFF_OUT = ls_off;
	assign READY_STATUS = ready;
	assign ERROR_LATCH = err;

	AST_POR_GATES_OFF: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		(state == gdsc_pkg::ST_POR) |=> !HIGH_SIDE_TURN_ON_OUT && !LOW_SIDE_TURN_ON_OUT)
		else $error("Gate on during power-on reset.");
	AST_POR_NOT_READY: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		(state == gdsc_pkg::ST_POR) |-> !READY_STATUS) else $error("Ready during reset.");
	AST_POR_LEN: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		(state == gdsc_pkg::ST_POR && !reached(cnt, POR_LEN)) |=> state == gdsc_pkg::ST_POR)
		else $error("Power-on reset ended early.");
	AST_READY_AT_END: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		(state == gdsc_pkg::ST_POR && reached(cnt, POR_LEN) && !fault)
		|=> READY_STATUS && state == gdsc_pkg::ST_RUN) else $error("Not ready after reset.");
	AST_STRAP_CAPTURE: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		(state == gdsc_pkg::ST_POR && reached(cnt, POR_LEN))
		|=> hs_dis == $past(HIGH_SIDE_FAULT_SHUTDOWN_DISABLE)
		&& ls_dis == $past(LOW_SIDE_FAULT_SHUTDOWN_DISABLE))
		else $error("Strap not captured.");
	AST_RUN_FORWARDS: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		(state == gdsc_pkg::ST_RUN && !fault) |=> HIGH_SIDE_TURN_ON_OUT == $past(gate.hs_req)
		&& LOW_SIDE_TURN_ON_OUT == $past(gate.ls_req)) else $error("Permitted pulse lost.");
	AST_OFF_IS_INVERSE: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		HIGH_SIDE_TURN_OFF_OUT != HIGH_SIDE_TURN_ON_OUT
		&& LOW_SIDE_TURN_OFF_OUT != LOW_SIDE_TURN_ON_OUT) else $error("Gate drives agree.");
	AST_FAULT_RESPONSE: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		(state == gdsc_pkg::ST_RUN && fault) |=> !READY_STATUS && ERROR_LATCH)
		else $error("Fault not flagged.");
	AST_FAULT_LATCHED: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		(state == gdsc_pkg::ST_FAULT) |-> ERROR_LATCH && !READY_STATUS)
		else $error("Fault state not flagged.");
	AST_FAULT_GATES_OFF: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		(state == gdsc_pkg::ST_FAULT && !hs_dis) |=> !HIGH_SIDE_TURN_ON_OUT)
		else $error("High side on during fault.");
	AST_LS_FAULT_GATES_OFF: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		(state == gdsc_pkg::ST_FAULT && !ls_dis) |=> !LOW_SIDE_TURN_ON_OUT)
		else $error("Low side on during fault.");
	AST_RECOVER_WAIT: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		($past(state) == gdsc_pkg::ST_FAULT && state == gdsc_pkg::ST_RUN)
		|-> $past(cnt) >= gdsc_pkg::CNT_W'(RECOVER_LEN - 1) && !$past(fault))
		else $error("Early recovery.");
	AST_DISABLED_PASSES: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		(state == gdsc_pkg::ST_FAULT && ls_dis && gate.ls_req) |=> LOW_SIDE_TURN_ON_OUT)
		else $error("Disabled shutdown still blocked.");
endmodule : gdsc_top
`default_nettype wire

// >>> dv/pwm_ctrl_model.sv
// Controller model that drives the two differential switching pairs.
`timescale 1ns/1ps
`default_nettype none
module pwm_ctrl_model #(
	parameter int MIN_PULSE = 500
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic arst_n,
	// Switching allowed; low keeps both pairs off.
	input wire logic go,
	// Differential pairs.
	output logic hs_p,
	output logic hs_n,
	output logic ls_p,
	output logic ls_n
);
	int hold;
	logic hs;
	logic ls;
	assign hs_p = hs;
	assign hs_n = ~hs;
	assign ls_p = ls;
	assign ls_n = ~ls;
	always @(negedge clk or negedge arst_n) begin
		if (!arst_n || !go) begin
			hs <= 1'b0;
			ls <= 1'b0;
			hold <= 0;
		end else if (hold < MIN_PULSE - 1) begin
			hold <= hold + 1;
		end else begin
			hs <= 1'($urandom_range(0, 1));
			ls <= 1'($urandom_range(0, 1));
			hold <= 0;
		end
	end
endmodule : pwm_ctrl_model
`default_nettype wire

// >>> dv/gate_driver_startup_control_bench.sv
// Self-checking bench for start-up, switching, fault and recovery of the driver control.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
	$display("CHECK FAILED t=%0t got %b exp %b", $time, got, exp); end end
module gate_driver_startup_control_bench;
	localparam int LIMIT = 30000;
	// Shortened interval lengths keep the run within a few tens of thousands of cycles.
	localparam int POR_LEN = 2000;
	localparam int RECOVER_LEN = 3000;
	logic SYS_CLK = 1'b0;
	logic ARST_N = 1'b0;
	logic HALT_REQ = 1'b0;
	logic FAULT_IN = 1'b0;
	logic HS_DIS = 1'b0;
	logic LS_DIS = 1'b0;
	logic go = 1'b0;
	logic HS_P, HS_N, LS_P, LS_N, HS_ON, HS_OFF, LS_ON, LS_OFF, READY, ERR;
	int num_errors = 0;
	int tests_run = 0;
	int cycles = 0;
	always #2 SYS_CLK = ~SYS_CLK;
	pwm_ctrl_model #(.MIN_PULSE(500)) ctrl (.clk(SYS_CLK), .arst_n(ARST_N), .go(go),
		.hs_p(HS_P), .hs_n(HS_N), .ls_p(LS_P), .ls_n(LS_N));
	gdsc_top #(.POR_LEN(POR_LEN), .RECOVER_LEN(RECOVER_LEN)) dut (.SYS_CLK(SYS_CLK),
		.ARST_N(ARST_N), .HS_IN_P(HS_P), .HS_IN_N(HS_N),
		.LS_IN_P(LS_P), .LS_IN_N(LS_N), .HALT_REQ(HALT_REQ), .FAULT_IN(FAULT_IN),
		.HIGH_SIDE_FAULT_SHUTDOWN_DISABLE(HS_DIS), .LOW_SIDE_FAULT_SHUTDOWN_DISABLE(LS_DIS),
		.HIGH_SIDE_TURN_ON_OUT(HS_ON), .HIGH_SIDE_TURN_OFF_OUT(HS_OFF),
		.LOW_SIDE_TURN_ON_OUT(LS_ON), .LOW_SIDE_TURN_OFF_OUT(LS_OFF),
		.READY_STATUS(READY), .ERROR_LATCH(ERR));
	function automatic logic exp_ready(input logic in_por);
		return in_por ? gdsc_pkg::STATUS_NOT_READY : ~gdsc_pkg::STATUS_NOT_READY;
	endfunction : exp_ready
	function automatic logic exp_on(input logic p, input logic n, input logic permit);
		return p & ~n & permit;
	endfunction : exp_on
	task automatic summarize();
		$display("Counts: %0d checks, %0d mismatches", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : summarize
	task automatic check_off();
		`CHK(HS_ON, gdsc_pkg::GATE_OFF)
		`CHK(LS_ON, gdsc_pkg::GATE_OFF)
		`CHK(HS_OFF, ~gdsc_pkg::GATE_OFF)
		`CHK(LS_OFF, ~gdsc_pkg::GATE_OFF)
		`CHK(READY, exp_ready(1'b1))
	endtask : check_off
	// Random halt, fault and strap levels while the reset interval is still running.
	task automatic run_por(input int n, input logic sw, input string name);
		go = sw;
		repeat (n) begin
			@(negedge SYS_CLK);
			HALT_REQ = 1'($urandom_range(0, 1));
			FAULT_IN = 1'($urandom_range(0, 1));
			HS_DIS = 1'($urandom_range(0, 1));
			LS_DIS = 1'($urandom_range(0, 1));
			check_off();
		end
		$display("Test %s done", name);
	endtask : run_por
	task automatic pulse_reset();
		@(negedge SYS_CLK);
		ARST_N = 1'b0;
		#1;
		check_off();
		`CHK(ERR, 1'b0)
		@(negedge SYS_CLK);
		ARST_N = 1'b1;
	endtask : pulse_reset
	// Settles straps and fault inputs, then checks the cycle at which ready rises.
	task automatic finish_por(input int done, input logic hs_dis, input logic ls_dis,
		input string name);
		for (int i = done + 1; i <= POR_LEN + 1; i++) begin
			@(negedge SYS_CLK);
			HALT_REQ = 1'b0;
			FAULT_IN = 1'b0;
			HS_DIS = hs_dis;
			LS_DIS = ls_dis;
			`CHK(READY, exp_ready(i < POR_LEN))
			`CHK(ERR, 1'b0)
		end
		$display("Test %s done", name);
	endtask : finish_por
	task automatic run_switch(input int n, input string name);
		repeat (n) begin
			@(posedge SYS_CLK);
			#1;
			`CHK(HS_ON, exp_on(HS_P, HS_N, 1'b1))
			`CHK(LS_ON, exp_on(LS_P, LS_N, 1'b1))
			`CHK(HS_OFF, ~exp_on(HS_P, HS_N, 1'b1))
			`CHK(LS_OFF, ~exp_on(LS_P, LS_N, 1'b1))
			`CHK(READY, exp_ready(1'b0))
		end
		$display("Test %s done", name);
	endtask : run_switch
	// One fault or halt held for hold cycles, inside a recovery wait counted from its onset.
	task automatic fault_cycle(input int hold, input logic use_halt, input string name);
		@(negedge SYS_CLK);
		HALT_REQ = use_halt;
		FAULT_IN = ~use_halt;
		for (int n = 1; n <= RECOVER_LEN + 1; n++) begin
			@(posedge SYS_CLK);
			#1;
			`CHK(READY, exp_ready(n <= RECOVER_LEN))
			`CHK(ERR, n <= RECOVER_LEN)
			`CHK(HS_ON, exp_on(HS_P, HS_N, HS_DIS))
			`CHK(LS_ON, exp_on(LS_P, LS_N, LS_DIS))
			`CHK(LS_OFF, ~exp_on(LS_P, LS_N, LS_DIS))
			if (n == hold) begin
				@(negedge SYS_CLK);
				HALT_REQ = 1'b0;
				FAULT_IN = 1'b0;
			end
		end
		$display("Test %s done", name);
	endtask : fault_cycle
	always @(posedge SYS_CLK) begin
		cycles++;
		if (cycles == LIMIT) begin
			num_errors++;
			summarize();
		end
	end
	initial begin
		void'($urandom(32'h96b8_ce64));
		repeat (2) @(negedge SYS_CLK);
		check_off();
		`CHK(ERR, 1'b0)
		ARST_N = 1'b1;
		run_por(600, 1'b0, "quiet controller");
		run_por(1200, 1'b1, "switching too early");
		pulse_reset();
		run_por(1500, 1'b1, "second reset");
		finish_por(1500, 1'b0, 1'b0, "straps enable shutdown");
		run_switch(1500, "forwarding");
		fault_cycle(1, 1'b0, "short fault");
		fault_cycle(int'($urandom_range(2, 200)), 1'b1, "halt request");
		pulse_reset();
		run_por(300, 1'b1, "third reset");
		finish_por(300, 1'b0, 1'b1, "low side strap disables shutdown");
		run_switch(1000, "forwarding again");
		fault_cycle(int'($urandom_range(2, 200)), 1'b0, "fault with low side passing");
		fault_cycle(RECOVER_LEN, 1'b1, "halt held to the end of the wait");
		summarize();
	end
endmodule : gate_driver_startup_control_bench
`default_nettype wire
